// >>> hw/prsreg_pkg.sv
package prsreg_pkg;
    localparam logic [7:0] OFF_STATUS_ALIAS  = 8'h00;
    localparam logic [7:0] OFF_P_OUT_HIGH    = 8'h01;
    localparam logic [7:0] OFF_P_OUT_MID     = 8'h02;
    localparam logic [7:0] OFF_P_OUT_LOW     = 8'h03;
    localparam logic [7:0] OFF_T_OUT_HIGH    = 8'h04;
    localparam logic [7:0] OFF_T_OUT_LOW     = 8'h05;
    localparam logic [7:0] OFF_DATA_READY    = 8'h06;
    localparam logic [7:0] OFF_P_CHG_HIGH    = 8'h07;
    localparam logic [7:0] OFF_P_CHG_MID     = 8'h08;
    localparam logic [7:0] OFF_P_CHG_LOW     = 8'h09;
    localparam logic [7:0] OFF_T_CHG_HIGH    = 8'h0a;
    localparam logic [7:0] OFF_T_CHG_LOW     = 8'h0b;
    localparam logic [7:0] OFF_IDENTITY      = 8'h0c;
    localparam logic [7:0] OFF_QUEUE_STATE   = 8'h0d;
    localparam logic [7:0] OFF_QUEUE_PORT    = 8'h0e;
    localparam logic [7:0] OFF_QUEUE_SETUP   = 8'h0f;
    localparam logic [7:0] OFF_OVF_TIME      = 8'h10;
    localparam logic [7:0] OFF_OP_MODE       = 8'h11;
    localparam logic [7:0] OFF_INT_CAUSES    = 8'h12;
    localparam logic [7:0] OFF_EVENT_CFG     = 8'h13;
    localparam logic [7:0] OFF_RESERVED_A    = 8'h14;
    localparam logic [7:0] OFF_RESERVED_B    = 8'h15;
    localparam logic [7:0] OFF_P_GOAL_HIGH   = 8'h16;
    localparam logic [7:0] OFF_P_GOAL_LOW    = 8'h17;
    localparam logic [7:0] OFF_T_GOAL        = 8'h18;
    localparam logic [7:0] OFF_P_BAND_HIGH   = 8'h19;
    localparam logic [7:0] OFF_P_BAND_LOW    = 8'h1a;
    localparam logic [7:0] OFF_T_BAND        = 8'h1b;
    localparam int         MAP_SIZE          = 28;
    localparam logic [7:0] RST_BYTE          = 8'h00;
    localparam int         QUEUE_MODE_MSB    = 7;
    localparam int         QUEUE_MODE_LSB    = 6;
    localparam int         RDY_T_BIT         = 1;
    localparam int         RDY_P_BIT         = 2;
    localparam int         RDY_ALL_BIT       = 3;
    localparam int         OVW_T_BIT         = 5;
    localparam int         OVW_P_BIT         = 6;
    localparam int         OVW_ALL_BIT       = 7;
endpackage

// >>> hw/prsreg_bank.sv
// Operation
// - Address 00h reads an alias of data-ready status or queue status.
// - With queue mode zero, address 00h shows the data-ready status.
// - Live 20-bit pressure split over 01h, 02h, 03h, high bits first.
// - Live 12-bit temperature split over 04h and 05h.
// - Auto-increment pointer wraps from 05h back to 00h.
// - Auto-increment pointer wraps from 0Bh back to 06h.
// - Queue read port at 0Eh keeps the pointer at 0Eh.
// - In queue mode, 01h is the queue root; pointer stays at 01h.
// - 20-bit pressure change split over 07h, 08h, 09h.
// - 12-bit temperature change split over 0Ah and 0Bh.
// - Data-ready status at 06h, also at 00h when queue disabled.
// - 0Ch returns fixed identity, untouched by standby-to-active.
// - Queue status at 0Dh reads zero after reset.
// - Queue setup at 0Fh is read/write, resets zero, survives activation.
// - 10h reports time elapsed since queue overflow.
// - 11h reports operating mode and clears on standby-to-active.
// - 12h reports pending interrupt causes, not cleared on activation.
// - 13h configures data event flags; read/write, resets zero.
// - 16-bit pressure goal at 16h/17h, read/write, resets zero.
// - 16-bit pressure band at 19h/1Ah, read/write, resets zero.
// - Flagged registers return to defaults on standby-to-active.
// - Contents are kept when going from active back to standby.
`timescale 1ns/1ps
module prsreg_bank #(
    parameter logic [7:0] IDENTITY_VALUE = 8'h5a // Arbitrary value
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_active,
    input  wire logic        i_ptr_load,
    input  wire logic [7:0]  i_ptr_addr,
    input  wire logic        i_wr_en,
    input  wire logic [7:0]  i_wr_data,
    input  wire logic        i_rd_en,
    input  wire logic        i_sample_valid,
    input  wire logic [19:0] i_pressure,
    input  wire logic [11:0] i_temperature,
    input  wire logic [7:0]  i_queue_status,
    input  wire logic [7:0]  i_queue_byte,
    input  wire logic [7:0]  i_overflow_time,
    input  wire logic [7:0]  i_int_causes,
    output logic [7:0]       o_rd_data,
    output logic [7:0]       o_ptr,
    output logic             o_queue_pop,
    output logic [7:0]       o_queue_setup,
    output logic [7:0]       o_event_flag_config,
    output logic [15:0]      o_pressure_goal,
    output logic [7:0]       o_temperature_goal,
    output logic [15:0]      o_pressure_band,
    output logic [7:0]       o_temperature_band
);
    localparam int MAP_SIZE = prsreg_pkg::MAP_SIZE;

    logic [7:0]  ptr_q;
    logic [7:0]  ptr_d;
    logic [7:0]  rd_data_q;
    logic        active_prev_q;
    logic [19:0] pressure_q;
    logic [11:0] temp_q;
    logic [19:0] p_chg_q;
    logic [11:0] t_chg_q;
    logic [7:0]  dr_q;
    logic [7:0]  dr_d;
    logic [7:0]  qstate_q;
    logic [7:0]  ovf_time_q;
    logic [7:0]  mode_q;
    logic [7:0]  causes_q;
    logic [7:0]  setup_q;
    logic [7:0]  cfg_q;
    logic [15:0] p_goal_q;
    logic [7:0]  t_goal_q;
    logic [15:0] p_band_q;
    logic [7:0]  t_band_q;
    logic [7:0]  rd_map [MAP_SIZE];

    wire activate   = i_active & ~active_prev_q;
    wire queue_on   = |setup_q[prsreg_pkg::QUEUE_MODE_MSB:
                               prsreg_pkg::QUEUE_MODE_LSB];
    wire xfer       = i_rd_en | i_wr_en;
    wire in_map     = ptr_q < 8'(MAP_SIZE);
    wire rd_root    = queue_on && ptr_q == prsreg_pkg::OFF_P_OUT_HIGH;
    wire rd_qport   = ptr_q == prsreg_pkg::OFF_QUEUE_PORT;
    wire pop        = i_rd_en & (rd_root | rd_qport);
    wire clr_ready  = i_rd_en & ~queue_on
                      & (ptr_q == prsreg_pkg::OFF_P_OUT_HIGH);
    wire [7:0] status_alias = queue_on ? qstate_q : dr_q;

    // Pointer advance after each byte
    assign ptr_d =
        (ptr_q == prsreg_pkg::OFF_T_OUT_LOW)  ? prsreg_pkg::OFF_STATUS_ALIAS :
        (ptr_q == prsreg_pkg::OFF_T_CHG_LOW)  ? prsreg_pkg::OFF_DATA_READY :
        rd_qport                              ? prsreg_pkg::OFF_QUEUE_PORT :
        rd_root                               ? prsreg_pkg::OFF_P_OUT_HIGH :
                                                ptr_q + 8'h01;

    assign rd_map[0]  = status_alias;
    assign rd_map[1]  = queue_on ? i_queue_byte : pressure_q[19:12];
    assign rd_map[2]  = pressure_q[11:4];
    assign rd_map[3]  = {pressure_q[3:0], 4'h0};
    assign rd_map[4]  = temp_q[11:4];
    assign rd_map[5]  = {temp_q[3:0], 4'h0};
    assign rd_map[6]  = dr_q;
    assign rd_map[7]  = p_chg_q[19:12];
    assign rd_map[8]  = p_chg_q[11:4];
    assign rd_map[9]  = {p_chg_q[3:0], 4'h0};
    assign rd_map[10] = t_chg_q[11:4];
    assign rd_map[11] = {t_chg_q[3:0], 4'h0};
    assign rd_map[12] = IDENTITY_VALUE;
    assign rd_map[13] = qstate_q;
    assign rd_map[14] = i_queue_byte;
    assign rd_map[15] = setup_q;
    assign rd_map[16] = ovf_time_q;
    assign rd_map[17] = mode_q;
    assign rd_map[18] = causes_q;
    assign rd_map[19] = cfg_q;
    assign rd_map[20] = prsreg_pkg::RST_BYTE;
    assign rd_map[21] = prsreg_pkg::RST_BYTE;
    assign rd_map[22] = p_goal_q[15:8];
    assign rd_map[23] = p_goal_q[7:0];
    assign rd_map[24] = t_goal_q;
    assign rd_map[25] = p_band_q[15:8];
    assign rd_map[26] = p_band_q[7:0];
    assign rd_map[27] = t_band_q;

    wire [7:0] rd_value = in_map ? rd_map[ptr_q[4:0]] : prsreg_pkg::RST_BYTE;

    // Write decode; read-only and reserved offsets have no strobe
    wire we_setup  = i_wr_en && ptr_q == prsreg_pkg::OFF_QUEUE_SETUP;
    wire we_cfg    = i_wr_en && ptr_q == prsreg_pkg::OFF_EVENT_CFG;
    wire we_pg_hi  = i_wr_en && ptr_q == prsreg_pkg::OFF_P_GOAL_HIGH;
    wire we_pg_lo  = i_wr_en && ptr_q == prsreg_pkg::OFF_P_GOAL_LOW;
    wire we_tgoal  = i_wr_en && ptr_q == prsreg_pkg::OFF_T_GOAL;
    wire we_pb_hi  = i_wr_en && ptr_q == prsreg_pkg::OFF_P_BAND_HIGH;
    wire we_pb_lo  = i_wr_en && ptr_q == prsreg_pkg::OFF_P_BAND_LOW;
    wire we_tband  = i_wr_en && ptr_q == prsreg_pkg::OFF_T_BAND;

    // New sample sets ready bits; a still-set bit turns into overwrite.
    // Set wins over the clear that a pressure read causes.
    wire [7:0] dr_base = clr_ready ? prsreg_pkg::RST_BYTE : dr_q;
    wire [7:0] dr_set  = i_sample_valid ? (8'h00
        | (8'h01 << prsreg_pkg::RDY_T_BIT)
        | (8'h01 << prsreg_pkg::RDY_P_BIT)
        | (8'h01 << prsreg_pkg::RDY_ALL_BIT)
        | (dr_q[prsreg_pkg::RDY_T_BIT]
           ? 8'h01 << prsreg_pkg::OVW_T_BIT : 8'h00)
        | (dr_q[prsreg_pkg::RDY_P_BIT]
           ? 8'h01 << prsreg_pkg::OVW_P_BIT : 8'h00)
        | (dr_q[prsreg_pkg::RDY_ALL_BIT]
           ? 8'h01 << prsreg_pkg::OVW_ALL_BIT : 8'h00))
        : 8'h00;
    assign dr_d = dr_base | dr_set;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr_q         <= prsreg_pkg::RST_BYTE;
            rd_data_q     <= prsreg_pkg::RST_BYTE;
            active_prev_q <= 1'b0;
        end else if (i_ce) begin
            active_prev_q <= i_active;
            if (i_ptr_load) begin
                ptr_q <= i_ptr_addr;
            end else if (xfer) begin
                ptr_q <= ptr_d;
            end
            if (i_rd_en) begin
                rd_data_q <= rd_value;
            end
        end
    end

    // Measured results and status; cleared on activation (data-ready also on a 01h
    // read with queue mode off), never on a return to standby
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pressure_q <= '0;
            temp_q     <= '0;
            p_chg_q    <= '0;
            t_chg_q    <= '0;
            dr_q       <= prsreg_pkg::RST_BYTE;
            qstate_q   <= prsreg_pkg::RST_BYTE;
            ovf_time_q <= prsreg_pkg::RST_BYTE;
            mode_q     <= prsreg_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (activate) begin
                pressure_q <= '0;
                temp_q     <= '0;
                p_chg_q    <= '0;
                t_chg_q    <= '0;
                dr_q       <= prsreg_pkg::RST_BYTE;
                qstate_q   <= prsreg_pkg::RST_BYTE;
                ovf_time_q <= prsreg_pkg::RST_BYTE;
                mode_q     <= prsreg_pkg::RST_BYTE;
            end else begin
                if (i_sample_valid) begin
                    pressure_q <= i_pressure;
                    temp_q     <= i_temperature;
                    p_chg_q    <= i_pressure - pressure_q;
                    t_chg_q    <= i_temperature - temp_q;
                end
                dr_q       <= dr_d;
                qstate_q   <= i_queue_status;
                ovf_time_q <= i_overflow_time;
                mode_q     <= {7'h00, i_active};
            end
        end
    end

    // Host-written setup and sampled interrupt causes; never touched by activation
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            causes_q <= prsreg_pkg::RST_BYTE;
            setup_q  <= prsreg_pkg::RST_BYTE;
            cfg_q    <= prsreg_pkg::RST_BYTE;
            p_goal_q <= '0;
            t_goal_q <= prsreg_pkg::RST_BYTE;
            p_band_q <= '0;
            t_band_q <= prsreg_pkg::RST_BYTE;
        end else if (i_ce) begin
            causes_q <= i_int_causes;
            if (we_setup) setup_q <= i_wr_data;
            if (we_cfg) cfg_q <= i_wr_data;
            if (we_pg_hi) p_goal_q[15:8] <= i_wr_data;
            if (we_pg_lo) p_goal_q[7:0] <= i_wr_data;
            if (we_tgoal) t_goal_q <= i_wr_data;
            if (we_pb_hi) p_band_q[15:8] <= i_wr_data;
            if (we_pb_lo) p_band_q[7:0] <= i_wr_data;
            if (we_tband) t_band_q <= i_wr_data;
        end
    end

    // No write lockout in active mode: the host is trusted to stay in
    // standby while writing setup, goals and bands
    assign o_rd_data           = rd_data_q;
    assign o_ptr               = ptr_q;
    assign o_queue_pop         = i_ce & pop;
    assign o_queue_setup       = setup_q;
    assign o_event_flag_config = cfg_q;
    assign o_pressure_goal     = p_goal_q;
    assign o_temperature_goal  = t_goal_q;
    assign o_pressure_band     = p_band_q;
    assign o_temperature_band  = t_band_q;

    property p_wrap_temp;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_ptr_load && xfer
            && ptr_q == prsreg_pkg::OFF_T_OUT_LOW)
            |=> ptr_q == prsreg_pkg::OFF_STATUS_ALIAS;
    endproperty
    a_wrap_temp: assert property (p_wrap_temp)
        else $error("pointer did not wrap 05h to 00h");

    property p_wrap_delta;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_ptr_load && xfer
            && ptr_q == prsreg_pkg::OFF_T_CHG_LOW)
            |=> ptr_q == prsreg_pkg::OFF_DATA_READY;
    endproperty
    a_wrap_delta: assert property (p_wrap_delta)
        else $error("pointer did not wrap 0Bh to 06h");

    property p_qport_hold;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_ptr_load && i_rd_en
            && ptr_q == prsreg_pkg::OFF_QUEUE_PORT)
            |-> o_queue_pop ##1 ptr_q == prsreg_pkg::OFF_QUEUE_PORT;
    endproperty
    a_qport_hold: assert property (p_qport_hold)
        else $error("queue port read moved pointer or missed pop");

    property p_root_hold;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_ptr_load && i_rd_en && queue_on
            && ptr_q == prsreg_pkg::OFF_P_OUT_HIGH)
            |=> ptr_q == prsreg_pkg::OFF_P_OUT_HIGH
                && o_rd_data == $past(i_queue_byte);
    endproperty
    a_root_hold: assert property (p_root_hold)
        else $error("queue root read misbehaved");

    property p_step;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_ptr_load && xfer && ptr_q == prsreg_pkg::OFF_OVF_TIME)
            |=> ptr_q == prsreg_pkg::OFF_OP_MODE;
    endproperty
    a_step: assert property (p_step)
        else $error("pointer did not advance by one");

    property p_alias_ready;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && !queue_on && ptr_q == prsreg_pkg::OFF_STATUS_ALIAS)
            |=> o_rd_data == $past(dr_q);
    endproperty
    a_alias_ready: assert property (p_alias_ready)
        else $error("status alias did not show data-ready state");

    property p_identity;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && ptr_q == prsreg_pkg::OFF_IDENTITY)
            |=> o_rd_data == IDENTITY_VALUE;
    endproperty
    a_identity: assert property (p_identity)
        else $error("identity read wrong");

    property p_reserved_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr_en && (ptr_q == prsreg_pkg::OFF_RESERVED_A
                     || ptr_q == prsreg_pkg::OFF_RESERVED_B))
            |=> $stable(p_goal_q) && $stable(setup_q) && $stable(cfg_q);
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved write altered state");

    property p_activate_clear;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && activate && !we_setup)
            |=> pressure_q == 20'h00000 && mode_q == 8'h00
                && $stable(setup_q);
    endproperty
    a_activate_clear: assert property (p_activate_clear)
        else $error("activation clear wrong");

    property p_goal_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && we_pg_lo) |=> o_pressure_goal[7:0] == $past(i_wr_data);
    endproperty
    a_goal_write: assert property (p_goal_write)
        else $error("pressure goal low byte not written");

    property p_pres_split;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && ptr_q == prsreg_pkg::OFF_P_OUT_MID)
            |=> o_rd_data == $past(pressure_q[11:4]);
    endproperty
    a_pres_split: assert property (p_pres_split)
        else $error("pressure middle byte wrong");

    property p_temp_split;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && ptr_q == prsreg_pkg::OFF_T_OUT_LOW)
            |=> o_rd_data == {$past(temp_q[3:0]), 4'h0};
    endproperty
    a_temp_split: assert property (p_temp_split)
        else $error("temperature low nibble byte wrong");

    property p_pchg_split;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && ptr_q == prsreg_pkg::OFF_P_CHG_HIGH)
            |=> o_rd_data == $past(p_chg_q[19:12]);
    endproperty
    a_pchg_split: assert property (p_pchg_split)
        else $error("pressure change high byte wrong");

    property p_tchg_split;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && i_rd_en && ptr_q == prsreg_pkg::OFF_T_CHG_LOW)
            |=> o_rd_data == {$past(t_chg_q[3:0]), 4'h0};
    endproperty
    a_tchg_split: assert property (p_tchg_split)
        else $error("temperature change low byte wrong");

    property p_causes_keep;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && activate)
            |=> causes_q == $past(i_int_causes);
    endproperty
    a_causes_keep: assert property (p_causes_keep)
        else $error("interrupt causes lost on activation");

    property p_cfg_write;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && we_cfg)
            |=> o_event_flag_config == $past(i_wr_data);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("event flag config not written");

    property p_keep_standby;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && !i_active && active_prev_q && !i_sample_valid)
            |=> $stable(pressure_q) && $stable(p_chg_q);
    endproperty
    a_keep_standby: assert property (p_keep_standby)
        else $error("results changed on return to standby");
endmodule // prsreg_bank

// >>> bench/prsreg_host.sv
`timescale 1ns/1ps
module prsreg_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rd_data,
    output logic            o_ptr_load,
    output logic [7:0]      o_ptr_addr,
    output logic            o_wr_en,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_en
);
    logic [7:0] q[$];
    initial begin
        o_ptr_load = 1'b0;
        o_ptr_addr = 8'h00;
        o_wr_en    = 1'b0;
        o_wr_data  = 8'h00;
        o_rd_en    = 1'b0;
    end
    // Idle byte lines show the inverse of the last byte, never a stale copy
    task automatic at(input logic [7:0] a);
        @(negedge i_clk);
        o_ptr_load = 1'b1;
        o_ptr_addr = a;
        @(negedge i_clk);
        o_ptr_load = 1'b0;
        o_ptr_addr = ~a;
    endtask
    task automatic rd_n(input int n);
        q.delete();
        @(negedge i_clk);
        o_rd_en = 1'b1;
        for (int k = 0; k < n; k++) begin
            @(negedge i_clk);
            o_rd_en = (k < n - 1);
            q.push_back(i_rd_data);
        end
    endtask
    // Callers issue setup, goal and band writes only in standby
    task automatic wr_n(input logic [7:0] b[$]);
        foreach (b[k]) begin
            @(negedge i_clk);
            o_wr_en = 1'b1;
            o_wr_data = b[k];
        end
        @(negedge i_clk);
        o_wr_en = 1'b0;
        o_wr_data = ~o_wr_data;
    endtask
endmodule // prsreg_host

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_ce = 1'b1;
    logic        i_active = 1'b0;
    logic        i_sample_valid = 1'b0;
    logic [19:0] i_pressure = 20'h00000;
    logic [11:0] i_temperature = 12'h000;
    logic [7:0]  i_queue_status = 8'h00;
    logic [7:0]  i_queue_byte = 8'h00;
    logic [7:0]  i_overflow_time = 8'h00;
    logic [7:0]  i_int_causes = 8'h00;
    logic        ptr_load, wr_en, rd_en, queue_pop;
    logic [7:0]  ptr_addr, wr_data, rd_data, ptr, setup, evcfg, tgoal, tband;
    logic [15:0] pgoal, pband;
    int          fail_count = 0, checks = 0, cycles = 0;
    int          pops = 0, exp_pops = 0;
    int          pres = 0, temp = 0, dp = 0, dt = 0, dr = 0, mptr = 0;
    int          rw[32];
    logic [7:0]  bq[$];

    always #10 i_clk = ~i_clk;

    prsreg_bank #(.IDENTITY_VALUE(ID)) prsreg_bank_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_active(i_active),
        .i_ptr_load(ptr_load), .i_ptr_addr(ptr_addr), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .i_sample_valid(i_sample_valid),
        .i_pressure(i_pressure), .i_temperature(i_temperature),
        .i_queue_status(i_queue_status), .i_queue_byte(i_queue_byte),
        .i_overflow_time(i_overflow_time), .i_int_causes(i_int_causes),
        .o_rd_data(rd_data), .o_ptr(ptr), .o_queue_pop(queue_pop),
        .o_queue_setup(setup), .o_event_flag_config(evcfg),
        .o_pressure_goal(pgoal), .o_temperature_goal(tgoal),
        .o_pressure_band(pband), .o_temperature_band(tband));

    prsreg_host prsreg_host_i (
        .i_clk(i_clk), .i_rd_data(rd_data), .o_ptr_load(ptr_load),
        .o_ptr_addr(ptr_addr), .o_wr_en(wr_en), .o_wr_data(wr_data),
        .o_rd_en(rd_en));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 210 cycles the sequence needs
    always @(posedge i_clk) begin
        cycles++;
        if (queue_pop === 1'b1) pops++;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR timeout expected done seen hang");
            complete_run();
        end
    end

    function automatic int nxt(int a);
        if (a == 5) return 0;
        if (a == 11) return 6;
        if (a == 14 || (a == 1 && rw[15][7:6] != 0)) return a;
        return (a + 1) % 256;
    endfunction

    function automatic logic [7:0] exp_rd(int a);
        logic qm;
        qm = rw[15][7:6] != 0;
        case (a)
            0: return qm ? i_queue_status : 8'(dr);
            1: return qm ? i_queue_byte : 8'(pres >> 12);
            2: return 8'(pres >> 4);
            3: return 8'((pres & 15) << 4);
            4: return 8'(temp >> 4);
            5: return 8'((temp & 15) << 4);
            6: return 8'(dr);
            7: return 8'(dp >> 12);
            8: return 8'(dp >> 4);
            9: return 8'((dp & 15) << 4);
            10: return 8'(dt >> 4);
            11: return 8'((dt & 15) << 4);
            12: return ID;
            13: return i_queue_status;
            14: return i_queue_byte;
            16: return i_overflow_time;
            17: return {7'h00, i_active};
            18: return i_int_causes;
            15, 19, 22, 23, 24, 25, 26, 27: return 8'(rw[a]);
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(string nm, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_seq(int a, int n);
        prsreg_host_i.at(8'(a));
        prsreg_host_i.rd_n(n);
        mptr = a;
        foreach (prsreg_host_i.q[k]) begin
            check($sformatf("reg %h", mptr), exp_rd(mptr), prsreg_host_i.q[k]);
            if (mptr == 14 || (mptr == 1 && rw[15][7:6] != 0)) exp_pops++;
            if (mptr == 1 && rw[15][7:6] == 0) dr = 0;
            mptr = nxt(mptr);
        end
        check("pointer", 8'(mptr), ptr);
        check("pops", 8'(exp_pops), 8'(pops));
    endtask

    task automatic wr_seq(int a);
        prsreg_host_i.at(8'(a));
        prsreg_host_i.wr_n(bq);
        mptr = a;
        foreach (bq[k]) begin
            if (mptr inside {15, 19, [22:27]}) rw[mptr] = bq[k];
            mptr = nxt(mptr);
        end
        check("pointer", 8'(mptr), ptr);
        check("setup", 8'(rw[15]), setup);
        check("event cfg", 8'(rw[19]), evcfg);
        check("p goal", 8'(rw[22]), pgoal[15:8]);
        check("p goal lo", 8'(rw[23]), pgoal[7:0]);
        check("t goal", 8'(rw[24]), tgoal);
        check("p band", 8'(rw[25]), pband[15:8]);
        check("p band lo", 8'(rw[26]), pband[7:0]);
        check("t band", 8'(rw[27]), tband);
    endtask

    task automatic sample();
        @(negedge i_clk);
        i_sample_valid = 1'b1;
        i_pressure = 20'($urandom);
        i_temperature = 12'($urandom);
        @(negedge i_clk);
        i_sample_valid = 1'b0;
        if (!i_ce) return;
        dp = (i_pressure - pres) & 32'hfffff;
        dt = (i_temperature - temp) & 32'hfff;
        pres = i_pressure;
        temp = i_temperature;
        dr = dr | 8'h0e | ((dr & 8'h0e) << 4);
    endtask

    initial begin
        void'($urandom(32'h569feb63));
        repeat (5) @(negedge i_clk);
        i_rst = 1'b0;
        rd_seq(0, 7);
        rd_seq(6, 7);
        rd_seq(12, 2);
        rd_seq(14, 3);
        rd_seq(15, 13);
        repeat (13) bq.push_back(8'($urandom));
        bq[0] = bq[0] & 8'h3f;
        wr_seq(15);
        wr_seq(12);
        i_queue_status = 8'($urandom);
        i_queue_byte = 8'($urandom);
        i_overflow_time = 8'($urandom);
        i_int_causes = 8'($urandom);
        rd_seq(15, 16);
        sample();
        sample();
        rd_seq(6, 7);
        rd_seq(0, 7);
        i_ce = 1'b0;
        sample();
        i_ce = 1'b1;
        rd_seq(1, 5);
        i_active = 1'b1;
        repeat (3) @(negedge i_clk);
        {pres, temp, dp, dt, dr} = '0;
        rd_seq(0, 13);
        rd_seq(12, 2);
        rd_seq(15, 16);
        sample();
        i_active = 1'b0;
        repeat (3) @(negedge i_clk);
        rd_seq(6, 7);
        bq = {8'h40};
        wr_seq(15);
        rd_seq(0, 1);
        rd_seq(1, 3);
        complete_run();
    end
endmodule // tb_top
